// >>> hdl/homing_pkg.sv
// Package for the home-return sequencer: mode codes, field layouts and timing.
// Assumes a single 20 MHz control clock shared by every user of the package.
package homing_pkg;
    // ------------------------------------------------------------------
    // Homing configuration word fields
    // ------------------------------------------------------------------
    localparam int TYPE_LSB = 0;
    localparam int TYPE_W = 4;
    localparam int DIR_LSB = 4;
    localparam int POL_LSB = 8;
    localparam logic [3:0] TYPE_DOG = 4'h0;
    localparam logic [3:0] TYPE_COUNT = 4'h1;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int FILTER_UNIT_NS = 1000;
    localparam int FILTER_UNIT_CYC = FILTER_UNIT_NS * (CLK_HZ / 1000000) / 1000;
    localparam int DOG_MIN_MS = 10;
    localparam int DOG_MIN_CYC = DOG_MIN_MS * (CLK_HZ / 1000);
    localparam int POS_W = 32;
    localparam int SPD_W = 16;
    localparam logic [15:0] FILTER_RESET = 16'h0000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN = 3'b001,
        ST_CREEP = 3'b010,
        ST_INDEX = 3'b011,
        ST_SHIFT = 3'b100,
        ST_DONE = 3'b101
    } home_state_t;
endpackage

// >>> hdl/dog_home_return_sequencer.sv
// Home-return sequencer: dog and count type homing, speed select, home load.
// Assumes position feedback and index pulse come from the same clock domain as
// the motion profile; the dog and selection pins are asynchronous.
`timescale 1ns/10ps
// How it works
// - Type digit zero selects dog type homing.
// - Decelerate at dog front end; home at first index after rear end plus shift.
// - Homing speed from start until the dog is detected.
// - Creep speed after the dog is detected.
// - Shift distance is counted from the index taken: first after the dog rear end, or first after the travel for count type.
// - Homing acceleration time constant replaces the normal one while homing.
// - At completion the current position register loads the home value.
// - External inputs are seen only after the input filter time.
// - Count type travels the after-dog distance, then takes the next index.
// - Count type accepts any dog held active at least 10 ms.
// - Index is used internally once per revolution and never output.
// - Direction digit 0 moves toward increasing, 1 toward decreasing addresses.
// - Polarity digit 0 detects dog when off, 1 when on.
module dog_home_return_sequencer
    import homing_pkg::*;
#(
    parameter int DOG_MIN_CYCLES = DOG_MIN_CYC
)(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic auto_manual_select_i,
    input wire logic table_select_bit1_i,
    input wire logic table_select_bit2_i,
    input wire logic table_select_bit3_i,
    input wire logic homing_program_cmd_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic dog_i,
    input wire logic index_pulse_i,
    input wire logic signed [POS_W-1:0] feedback_pos_i,
    input wire logic [15:0] homing_type_cfg_i,
    input wire logic [SPD_W-1:0] homing_speed_cfg_i,
    input wire logic [SPD_W-1:0] creep_speed_cfg_i,
    input wire logic [POS_W-1:0] home_shift_cfg_i,
    input wire logic [15:0] homing_accel_cfg_i,
    input wire logic [15:0] normal_accel_cfg_i,
    input wire logic signed [POS_W-1:0] home_value_cfg_i,
    input wire logic [POS_W-1:0] after_dog_travel_cfg_i,
    input wire logic [15:0] input_filter_cfg_i,
    output logic [SPD_W-1:0] speed_cmd_o,
    output logic dir_neg_o,
    output logic [15:0] accel_time_o,
    output logic busy_o,
    output logic home_done_o,
    output logic pos_load_o,
    output logic signed [POS_W-1:0] current_pos_o
);
    // ------------------------------------------------------------------
    // Pin synchronisers and input filter
    // ------------------------------------------------------------------
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    logic [6:0] filt_r;
    logic [6:0] filt_nxt;
    logic [15:0] fcnt_r [7];
    logic [15:0] fcnt_nxt [7];
    logic [7:0] unit_r;
    logic [7:0] unit_nxt;
    logic unit_tick;
    logic [6:0] raw_pins;

    assign raw_pins = {table_select_bit3_i, start_i, abort_i, auto_manual_select_i,
                       table_select_bit1_i, table_select_bit2_i, dog_i};

    always_comb
    begin
        unit_tick = (unit_r == 8'(FILTER_UNIT_CYC - 1));
        unit_nxt = unit_tick ? 8'h00 : unit_r + 8'h01;
    end

    // Each pin only changes once its new level has held for the filter time.
    genvar g;
    generate
        for (g = 0; g < 7; g++)
        begin : g_filt
            always_comb
            begin
                filt_nxt[g] = filt_r[g];
                fcnt_nxt[g] = fcnt_r[g];
                if (sync2_r[g] == filt_r[g])
                begin
                    fcnt_nxt[g] = 16'h0000;
                end
                else if (fcnt_r[g] >= input_filter_cfg_i)
                begin
                    filt_nxt[g] = sync2_r[g];
                    fcnt_nxt[g] = 16'h0000;
                end
                else if (unit_tick)
                begin
                    fcnt_nxt[g] = fcnt_r[g] + 16'h0001;
                end
            end
            always_ff @(posedge clock_i)
            begin
                if (!resetn_i)
                begin
                    fcnt_r[g] <= FILTER_RESET;
                end
                else
                begin
                    fcnt_r[g] <= fcnt_nxt[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            sync1_r <= 7'h00;
            sync2_r <= 7'h00;
            filt_r <= 7'h00;
            unit_r <= 8'h00;
        end
        else
        begin
            sync1_r <= raw_pins;
            sync2_r <= sync1_r;
            filt_r <= filt_nxt;
            unit_r <= unit_nxt;
        end
    end

    logic start_f;
    logic abort_f;
    logic mode_ok;
    logic dog_lvl;
    logic start_prev_r;

    assign start_f = filt_r[5];
    assign abort_f = filt_r[4];
    // Table method needs all three select bits off; program method needs the
    // selected program to carry the homing command.
    assign mode_ok = filt_r[3] & ((!filt_r[2] & !filt_r[1] & !filt_r[6])
                                  | homing_program_cmd_i);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    home_state_t state_r;
    home_state_t state_nxt;
    logic [3:0] type_r;
    logic [3:0] type_nxt;
    logic dir_r;
    logic dir_nxt;
    logic pol_r;
    logic pol_nxt;
    logic [POS_W-1:0] dist_r;
    logic [POS_W-1:0] dist_nxt;
    logic [31:0] dogcnt_r;
    logic [31:0] dogcnt_nxt;
    logic dog_seen_r;
    logic dog_seen_nxt;
    logic signed [POS_W-1:0] cur_r;
    logic signed [POS_W-1:0] cur_nxt;
    logic signed [POS_W-1:0] last_fb_r;
    logic [SPD_W-1:0] spd_nxt;
    logic [15:0] acc_nxt;
    logic done_nxt;
    logic load_nxt;
    logic signed [POS_W-1:0] delta;
    logic [POS_W-1:0] step;
    logic [SPD_W-1:0] hspd_r, hspd_nxt;
    logic [SPD_W-1:0] cspd_r, cspd_nxt;
    logic [15:0] hacc_r, hacc_nxt;
    logic [POS_W-1:0] shift_r, shift_nxt;
    logic [POS_W-1:0] adt_r, adt_nxt;
    logic signed [POS_W-1:0] hval_r, hval_nxt;

    assign dog_lvl = pol_r ? filt_r[0] : !filt_r[0];
    assign delta = feedback_pos_i - last_fb_r;
    assign step = delta[POS_W-1] ? POS_W'(-delta) : POS_W'(delta);

    always_comb
    begin
        state_nxt = state_r;
        type_nxt = type_r;
        dir_nxt = dir_r;
        pol_nxt = pol_r;
        dist_nxt = dist_r;
        dogcnt_nxt = dogcnt_r;
        dog_seen_nxt = dog_seen_r;
        cur_nxt = cur_r + delta;
        // Settings follow their inputs while idle and freeze at the start edge, so a
        // controller rewriting them mid-run cannot bend the sequence in flight.
        hspd_nxt = (state_r == ST_IDLE) ? homing_speed_cfg_i : hspd_r;
        cspd_nxt = (state_r == ST_IDLE) ? creep_speed_cfg_i : cspd_r;
        hacc_nxt = (state_r == ST_IDLE) ? homing_accel_cfg_i : hacc_r;
        shift_nxt = (state_r == ST_IDLE) ? home_shift_cfg_i : shift_r;
        adt_nxt = (state_r == ST_IDLE) ? after_dog_travel_cfg_i : adt_r;
        hval_nxt = (state_r == ST_IDLE) ? home_value_cfg_i : hval_r;
        done_nxt = 1'b0;
        load_nxt = 1'b0;
        spd_nxt = 16'h0000;
        acc_nxt = normal_accel_cfg_i;
        if (state_r != ST_IDLE && state_r != ST_DONE)
        begin
            acc_nxt = hacc_r;
        end
        case (state_r)
            ST_IDLE:
            begin
                if (start_f && !start_prev_r && mode_ok && !abort_f)
                begin
                    type_nxt = homing_type_cfg_i[TYPE_LSB +: TYPE_W];
                    dir_nxt = homing_type_cfg_i[DIR_LSB];
                    pol_nxt = homing_type_cfg_i[POL_LSB];
                    dist_nxt = 32'h0000_0000;
                    dogcnt_nxt = 32'h0000_0000;
                    dog_seen_nxt = 1'b0;
                    if (homing_type_cfg_i[TYPE_LSB +: TYPE_W] == TYPE_DOG ||
                        homing_type_cfg_i[TYPE_LSB +: TYPE_W] == TYPE_COUNT)
                    begin
                        state_nxt = ST_RUN;
                    end
                end
            end
            ST_RUN:
            begin
                spd_nxt = hspd_r;
                if (dog_lvl)
                begin
                    state_nxt = ST_CREEP;
                    dogcnt_nxt = 32'h0000_0001;
                end
            end
            ST_CREEP:
            begin
                spd_nxt = cspd_r;
                if (type_r == TYPE_DOG)
                begin
                    if (!dog_lvl)
                    begin
                        state_nxt = ST_INDEX;
                    end
                end
                else
                begin
                    dist_nxt = dist_r + step;
                    if (dog_lvl && dogcnt_r < 32'(DOG_MIN_CYCLES))
                    begin
                        dogcnt_nxt = dogcnt_r + 32'h0000_0001;
                    end
                    if (dogcnt_r >= 32'(DOG_MIN_CYCLES))
                    begin
                        dog_seen_nxt = 1'b1;
                    end
                    if (dist_r >= adt_r &&
                        (dog_seen_r || dogcnt_r >= 32'(DOG_MIN_CYCLES)))
                    begin
                        state_nxt = ST_INDEX;
                    end
                end
            end
            ST_INDEX:
            begin
                spd_nxt = cspd_r;
                if (index_pulse_i)
                begin
                    state_nxt = ST_SHIFT;
                    dist_nxt = 32'h0000_0000;
                end
            end
            ST_SHIFT:
            begin
                spd_nxt = cspd_r;
                dist_nxt = dist_r + step;
                if (dist_r >= shift_r)
                begin
                    state_nxt = ST_DONE;
                    cur_nxt = hval_r;
                    load_nxt = 1'b1;
                end
            end
            ST_DONE:
            begin
                done_nxt = 1'b1;
                if (!start_f)
                begin
                    state_nxt = ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (abort_f && state_r != ST_IDLE)
        begin
            state_nxt = ST_IDLE;
            spd_nxt = 16'h0000;
            load_nxt = 1'b0;
            done_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            state_r <= ST_IDLE;
            type_r <= 4'h0;
            dir_r <= 1'b0;
            pol_r <= 1'b0;
            dist_r <= 32'h0000_0000;
            dogcnt_r <= 32'h0000_0000;
            dog_seen_r <= 1'b0;
            cur_r <= 32'sh0000_0000;
            last_fb_r <= 32'sh0000_0000;
            start_prev_r <= 1'b0;
            hspd_r <= 16'h0000;
            cspd_r <= 16'h0000;
            hacc_r <= 16'h0000;
            shift_r <= 32'h0000_0000;
            adt_r <= 32'h0000_0000;
            hval_r <= 32'sh0000_0000;
            speed_cmd_o <= 16'h0000;
            dir_neg_o <= 1'b0;
            accel_time_o <= 16'h0000;
            busy_o <= 1'b0;
            home_done_o <= 1'b0;
            pos_load_o <= 1'b0;
            current_pos_o <= 32'sh0000_0000;
        end
        else
        begin
            state_r <= state_nxt;
            type_r <= type_nxt;
            dir_r <= dir_nxt;
            pol_r <= pol_nxt;
            dist_r <= dist_nxt;
            dogcnt_r <= dogcnt_nxt;
            dog_seen_r <= dog_seen_nxt;
            cur_r <= cur_nxt;
            last_fb_r <= feedback_pos_i;
            start_prev_r <= start_f;
            hspd_r <= hspd_nxt;
            cspd_r <= cspd_nxt;
            hacc_r <= hacc_nxt;
            shift_r <= shift_nxt;
            adt_r <= adt_nxt;
            hval_r <= hval_nxt;
            speed_cmd_o <= spd_nxt;
            dir_neg_o <= dir_nxt;
            accel_time_o <= acc_nxt;
            busy_o <= (state_nxt != ST_IDLE) && (state_nxt != ST_DONE);
            home_done_o <= done_nxt;
            pos_load_o <= load_nxt;
            current_pos_o <= cur_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_run_speed: assert property (@(posedge clock_i) disable iff (!resetn_i)
        state_r == ST_RUN && !abort_f |=> speed_cmd_o == $past(hspd_r))
        else $error("run speed wrong");
    a_creep_speed: assert property (@(posedge clock_i) disable iff (!resetn_i)
        state_r == ST_CREEP && !abort_f |=> speed_cmd_o == $past(cspd_r))
        else $error("creep speed wrong");
    a_dog_front: assert property (@(posedge clock_i) disable iff (!resetn_i)
        state_r == ST_RUN && dog_lvl && !abort_f |=> state_r == ST_CREEP)
        else $error("dog front missed");
    a_dog_rear: assert property (@(posedge clock_i) disable iff (!resetn_i)
        state_r == ST_CREEP && type_r == TYPE_DOG && !dog_lvl && !abort_f
        |=> state_r == ST_INDEX)
        else $error("dog rear missed");
    a_index_take: assert property (@(posedge clock_i) disable iff (!resetn_i)
        state_r == ST_INDEX && index_pulse_i && !abort_f |=> state_r == ST_SHIFT
        && dist_r == 32'h0000_0000)
        else $error("index not taken");
    a_home_load: assert property (@(posedge clock_i) disable iff (!resetn_i)
        pos_load_o && !abort_f |-> current_pos_o == $past(hval_r) ##1 home_done_o)
        else $error("home value not loaded");
    a_accel_sel: assert property (@(posedge clock_i) disable iff (!resetn_i)
        state_r inside {ST_RUN, ST_CREEP, ST_INDEX, ST_SHIFT} && !abort_f
        |=> accel_time_o == $past(hacc_r))
        else $error("homing accel not used");
    a_count_dog: assert property (@(posedge clock_i) disable iff (!resetn_i)
        state_r == ST_CREEP && type_r == TYPE_COUNT && state_nxt == ST_INDEX
        |-> dogcnt_r >= 32'(DOG_MIN_CYCLES) || dog_seen_r)
        else $error("short dog accepted");
    a_hold_cfg: assert property (@(posedge clock_i) disable iff (!resetn_i)
        state_r != ST_IDLE && $past(state_r) != ST_IDLE |-> $stable(dir_r) && $stable(type_r)
        && $stable(hspd_r) && $stable(cspd_r) && $stable(shift_r) && $stable(hval_r))
        else $error("config changed mid homing");
    a_cfg_capture: assert property (@(posedge clock_i) disable iff (!resetn_i)
        state_r == ST_IDLE && state_nxt == ST_RUN |=> hspd_r == $past(homing_speed_cfg_i)
        && hval_r == $past(home_value_cfg_i))
        else $error("settings not captured at start");
    c_dog_home: cover property (@(posedge clock_i) disable iff (!resetn_i)
        type_r == TYPE_DOG && pos_load_o);
    c_count_home: cover property (@(posedge clock_i) disable iff (!resetn_i)
        type_r == TYPE_COUNT && pos_load_o);
    c_abort: cover property (@(posedge clock_i) disable iff (!resetn_i)
        state_r == ST_CREEP && abort_f);
endmodule

// >>> testbench/homing_partner.sv
// Far side of the sequencer: motor position, once-per-turn index and dog switch.
// Assumes the speed command is in position units per clock, on the same clock.
`timescale 1ns/10ps
module homing_partner
    import homing_pkg::*;
#(
    parameter int DOG_LO = 200,
    parameter int DOG_HI = 416,
    parameter int REV_SH = 6
)(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic pol_on_i,
    input wire logic [SPD_W-1:0] speed_i,
    input wire logic dir_neg_i,
    output logic signed [POS_W-1:0] pos_o,
    output logic index_o,
    output logic dog_o
);
    logic signed [POS_W-1:0] pos_nxt;
    logic in_dog;

    always_comb
    begin
        if (dir_neg_i)
            pos_nxt = pos_o - $signed({16'h0000, speed_i});
        else
            pos_nxt = pos_o + $signed({16'h0000, speed_i});
        // The rear end sits midway between two index positions.
        in_dog = (pos_o >= DOG_LO) && (pos_o < DOG_HI);
        dog_o = in_dog ~^ pol_on_i;
    end

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            pos_o <= 32'sh00000000;
            index_o <= 1'b0;
        end
        else
        begin
            pos_o <= pos_nxt;
            index_o <= (pos_nxt >>> REV_SH) != (pos_o >>> REV_SH);
        end
    end
endmodule

// >>> testbench/dog_home_return_sequencer_tb.sv
// Self-checking bench for the home-return sequencer with a motor and dog model.
// Assumes the design holds its own assertions; this file only drives and compares.
`timescale 1ns/10ps
module dog_home_return_sequencer_tb;
    import homing_pkg::*;
    localparam int HS = 8;
    localparam int CS = 2;
    localparam int SHIFT = 10;
    localparam int DOG_LO = 200;
    localparam int DOG_HI = 416;
    localparam logic [15:0] HA = 16'h0055;
    localparam logic [15:0] NA = 16'h00aa;
    localparam logic [POS_W-1:0] HV = 32'h00001234;

    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic motor_rst_n = 1'b0;
    logic manual = 1'b1;
    logic [2:0] tsel = 3'h0;
    logic prog_cmd = 1'b0;
    logic start = 1'b0;
    logic abort = 1'b0;
    logic [15:0] type_cfg = 16'h0000;
    logic [15:0] filt = 16'h0000;
    logic [SPD_W-1:0] hs_cfg = 16'h0008;
    logic [POS_W-1:0] adt_cfg = 32'h00000028;
    logic signed [POS_W-1:0] pos;
    logic signed [POS_W-1:0] idx_pos = 32'sh00000000;
    logic index_pulse;
    logic dog;
    logic [SPD_W-1:0] speed_cmd_o;
    logic dir_neg_o;
    logic [15:0] accel_time_o;
    logic busy_o;
    logic home_done_o;
    logic pos_load_o;
    logic signed [POS_W-1:0] current_pos_o;
    int n_mismatch = 0;
    int comparisons = 0;

    dog_home_return_sequencer #(.DOG_MIN_CYCLES(20)) uut (
        .clock_i(clock_i), .resetn_i(resetn_i), .auto_manual_select_i(manual),
        .table_select_bit1_i(tsel[0]), .table_select_bit2_i(tsel[1]),
        .table_select_bit3_i(tsel[2]), .homing_program_cmd_i(prog_cmd),
        .start_i(start), .abort_i(abort), .dog_i(dog), .index_pulse_i(index_pulse),
        .feedback_pos_i(pos), .homing_type_cfg_i(type_cfg), .homing_speed_cfg_i(hs_cfg),
        .creep_speed_cfg_i(16'h0002), .home_shift_cfg_i(32'h0000000a),
        .homing_accel_cfg_i(HA), .normal_accel_cfg_i(NA), .home_value_cfg_i(HV),
        .after_dog_travel_cfg_i(adt_cfg), .input_filter_cfg_i(filt),
        .speed_cmd_o(speed_cmd_o), .dir_neg_o(dir_neg_o), .accel_time_o(accel_time_o),
        .busy_o(busy_o), .home_done_o(home_done_o), .pos_load_o(pos_load_o),
        .current_pos_o(current_pos_o)
    );

    homing_partner #(.DOG_LO(DOG_LO), .DOG_HI(DOG_HI), .REV_SH(6)) motor (
        .clock_i(clock_i), .resetn_i(motor_rst_n), .pol_on_i(type_cfg[POL_LSB]),
        .speed_i(speed_cmd_o), .dir_neg_i(dir_neg_o), .pos_o(pos),
        .index_o(index_pulse), .dog_o(dog)
    );

    initial
    begin
        forever #25 clock_i = ~clock_i;
    end

    // The last index seen while busy is the one the home was taken from.
    always @(posedge clock_i)
    begin
        if (index_pulse === 1'b1 && busy_o === 1'b1)
            idx_pos <= pos;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #5;
    endtask

    task automatic check(input logic [POS_W-1:0] seen, input logic [POS_W-1:0] exp,
                         input string what);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Waits, within a bound, for 0 busy, 1 creep speed, 2 load pulse, 3 idle.
    task automatic wait_on(input int which, input int lim);
        for (int k = 0; k < lim; k++)
        begin
            if ((which == 0 && busy_o === 1'b1) || (which == 1 && speed_cmd_o === CS) ||
                (which == 2 && pos_load_o === 1'b1) || (which == 3 && busy_o === 1'b0))
                break;
            tick(1);
        end
    endtask

    // Selection inputs settle long before the start edge.
    task automatic launch(input logic [15:0] typ);
        start = 1'b0;
        motor_rst_n = 1'b0;
        tick(60);
        motor_rst_n = 1'b1;
        type_cfg = typ;
        tick(1);
        start = 1'b1;
    endtask

    task automatic finish_checks();
        wait_on(2, 600);
        check(pos_load_o, 1'b1, "load pulse");
        check((pos - idx_pos >= SHIFT) && (pos - idx_pos < SHIFT + 4 * CS), 1'b1, "shift");
        check(current_pos_o, HV, "home value");
        tick(1);
        check({home_done_o, busy_o}, 2'b10, "done");
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic mode_refused();
        tsel = 3'h2;
        launch(16'h0000);
        tick(40);
        check(busy_o, 1'b0, "mode bits set");
        tsel = 3'h0;
        manual = 1'b0;
        launch(16'h0000);
        tick(40);
        check(busy_o, 1'b0, "auto mode");
        manual = 1'b1;
        launch(16'h0002);
        tick(40);
        check(busy_o, 1'b0, "bad type");
    endtask

    task automatic dog_run(input logic pol);
        launch({7'h00, pol, 4'h0, TYPE_DOG});
        wait_on(0, 50);
        // Speed and time constant follow busy by one cycle.
        tick(1);
        check(speed_cmd_o, HS, "homing speed");
        check(accel_time_o, HA, "homing accel");
        check(dir_neg_o, 1'b0, "forward");
        hs_cfg = 16'h0030;
        tick(2);
        check(speed_cmd_o, HS, "speed held");
        wait_on(1, 200);
        check(pos >= DOG_LO && pos < DOG_LO + 64, 1'b1, "creep at dog");
        finish_checks();
        check(idx_pos >= DOG_HI && idx_pos < DOG_HI + 64, 1'b1, "index past dog");
        hs_cfg = 16'h0008;
    endtask

    task automatic count_run();
        tsel = 3'h5;
        prog_cmd = 1'b1;
        launch({7'h00, 1'b1, 4'h0, TYPE_COUNT});
        wait_on(0, 50);
        check(busy_o, 1'b1, "program start");
        finish_checks();
        check(idx_pos >= DOG_LO + 40 && idx_pos < DOG_HI, 1'b1, "count index");
        tsel = 3'h0;
        prog_cmd = 1'b0;
    endtask

    task automatic abort_reverse();
        filt = 16'h0002;
        launch({7'h00, 1'b1, 3'h0, 1'b1, TYPE_DOG});
        tick(20);
        check(busy_o, 1'b0, "filter delay");
        wait_on(0, 60);
        check({busy_o, dir_neg_o}, 2'b11, "reverse start");
        tick(2);
        check(pos < 0, 1'b1, "moving down");
        abort = 1'b1;
        wait_on(3, 80);
        check(busy_o, 1'b0, "aborted");
        tick(1);
        check(accel_time_o, NA, "normal accel");
        abort = 1'b0;
        filt = 16'h0000;
    endtask

    task automatic complete_run();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #2000000;
        n_mismatch++;
        complete_run();
    end

    initial
    begin
        tick(6);
        resetn_i = 1'b1;
        motor_rst_n = 1'b1;
        tick(2);
        check({busy_o, home_done_o, pos_load_o}, 3'b000, "reset flags");
        check(accel_time_o, NA, "reset accel");
        mode_refused();
        dog_run(1'b0);
        dog_run(1'b1);
        count_run();
        abort_reverse();
        complete_run();
    end
endmodule
